// *** core/cpc_config_protect.sv ***
// Converter configuration registers with input gating, phase_stagger_config sync and over-voltage protection
`timescale 1ns/1ps
module cpc_config_protect
  import cpc_pkg::*;
#(
  parameter int unsigned HICCUP_CYC = HICCUP_UNIT_CYC
)
(
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        arst_n_in,
  // Command port
  input  wire cpc_cmd_t    cmd_in,
  output cpc_rsp_t         rsp_out,
  // Measurements and status
  input  wire logic [15:0] vin_meas_in,
  input  wire logic [15:0] vout_meas_in,
  input  wire logic        init_done_in,
  input  wire logic        operation_on_in,
  input  wire logic        ctrl_pin_in,
  // Power stage
  input  wire logic [15:0] duty_req_in,
  input  wire logic        pwm_cycle_start_in,
  output logic [15:0]      duty_cmd_out,
  output logic [15:0]      freq_out,
  output logic             power_en_out,
  output logic             power_good_out,
  output cpc_stag_t        stagger_cfg_out,
  // Sync pin
  input  wire logic        sync_pin_in,
  output logic             sync_pin_out,
  output logic             sync_pin_oe_out,
  output logic             sync_rx_out,
  // Alert line, open drain
  output logic             alert_line_n_out,
  output logic             alert_line_oe_out
);

  cpc_state_t          s_r;
  cpc_state_t          s_nxt;
  logic [4:0][15:0]    l11_code;
  logic signed [47:0]  fx [5];
  logic                want_on;
  logic                re_en;
  logic                ov_fault;
  logic                exhausted;
  logic                wait_done;
  logic                master;
  logic [6:0]          retry_lim;
  logic [31:0]         wait_tgt;
  logic                cmd_ok;
  logic                known;
  logic                exp_word;
  logic [15:0]         cur;
  logic                ctrl_f_nxt;
  logic                vin_ok_nxt;

  // Operands: input, turn-on, turn-off, duty request, duty ceiling
  assign l11_code = {s_r.duty, duty_req_in, s_r.voff, s_r.von, vin_meas_in};

  // One converter per linear11 operand
  for (genvar i = 0; i < 5; i++)
  begin : g_l11
    cpc_lin11_fix u_fix (
      .code_in (l11_code[i]),
      .fix_out (fx[i])
    );
  end

  // Filtered pin and input window, outside the state process so nothing loops back into it
  assign ctrl_f_nxt = (s_r.ctrl_s[1] == s_r.ctrl_s[2]) ? s_r.ctrl_s[2] : s_r.ctrl_f;
  assign vin_ok_nxt = s_r.vin_ok ? ~(fx[0] <= fx[2]) : (fx[0] >= fx[1]);

  // Enable sources; rising pin or command, or input loss, clears a latch
  assign want_on = vin_ok_nxt & s_r.ctrl_f & operation_on_in;
  assign re_en = (ctrl_f_nxt & ~s_r.ctrl_f) | (operation_on_in & ~s_r.op_q) |
                 (s_r.vin_ok & ~vin_ok_nxt);
  // Not looked at until initialisation is over
  assign ov_fault = init_done_in & (vout_meas_in > s_r.ovlim);
  assign retry_lim = 7'h01 << s_r.ovact.retry;
  assign exhausted = (s_r.ovact.retry != RETRY_FOREVER) & (s_r.tries >= retry_lim);
  assign wait_tgt = 32'(HICCUP_CYC) << s_r.ovact.dly;
  assign wait_done = (s_r.wait_cnt >= wait_tgt - 32'h1);
  assign master = (s_r.stag.pos == 4'h0);

  // Command decode; size must match, unknown codes are refused
  always_comb
  begin
    known = 1'b1;
    cur = 16'h0000;
    case (cmd_in.code)
      CMD_DUTY:  cur = s_r.duty;
      CMD_FREQ:  cur = s_r.freq;
      CMD_VON:   cur = s_r.von;
      CMD_VOFF:  cur = s_r.voff;
      CMD_STAG:  cur = s_r.stag;
      CMD_OVLIM: cur = s_r.ovlim;
      CMD_OVACT: cur = {8'h00, s_r.ovact};
      default:   known = 1'b0;
    endcase
    exp_word = (cmd_in.code != CMD_OVACT);
    cmd_ok = known & (cmd_in.word == exp_word) &
             ~(cmd_in.write & (cmd_in.code == CMD_FREQ) & s_r.out_en);
  end

  // Next state
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rsp = '0;
    s_nxt.sync_o = 1'b0;
    s_nxt.sync_rx = 1'b0;

    // Pin synchronisers; a level counts once stages two and three agree
    s_nxt.ctrl_s = {s_r.ctrl_s[1:0], ctrl_pin_in};
    s_nxt.ctrl_f = ctrl_f_nxt;
    s_nxt.sync_s = {s_r.sync_s[1:0], sync_pin_in};
    if (s_r.sync_s[1] == s_r.sync_s[2])
      s_nxt.sync_f = s_r.sync_s[2];
    s_nxt.op_q = operation_on_in;

    // Register access
    if (cmd_in.valid)
    begin
      s_nxt.rsp.valid = 1'b1;
      s_nxt.rsp.refused = ~cmd_ok;
      if (cmd_ok & ~cmd_in.write)
        s_nxt.rsp.rdata = cur;
      if (cmd_ok & cmd_in.write)
      begin
        case (cmd_in.code)
          CMD_DUTY:  s_nxt.duty = cmd_in.wdata;
          CMD_FREQ:  s_nxt.freq = cmd_in.wdata;
          CMD_VON:   s_nxt.von = cmd_in.wdata;
          CMD_VOFF:  s_nxt.voff = cmd_in.wdata;
          CMD_STAG:  s_nxt.stag = cmd_in.wdata;
          CMD_OVLIM: s_nxt.ovlim = cmd_in.wdata;
          CMD_OVACT: s_nxt.ovact = cmd_in.wdata[7:0];
          default:   s_nxt.rsp.refused = 1'b1;
        endcase
      end
    end

    // Input hysteresis; power good follows it
    s_nxt.vin_ok = vin_ok_nxt;

    // Duty clamp, compared as decoded values
    s_nxt.duty_cmd = (fx[3] > fx[4]) ? s_r.duty : duty_req_in;

    // Phase_stagger_config: position zero drives the chain, others listen
    s_nxt.sync_oe = master;
    s_nxt.sync_o = master & s_r.out_en & pwm_cycle_start_in;
    s_nxt.sync_rx = ~master & ~s_r.sync_f & s_r.sync_s[2] & (s_r.sync_s[1] == s_r.sync_s[2]);

    // Alert is held until a re-enable event
    if (re_en)
      s_nxt.alert = 1'b0;

    unique case (s_r.mode)
      ST_OFF:
      begin
        s_nxt.tries = 7'h00;
        s_nxt.out_en = 1'b0;
        if (want_on)
        begin
          s_nxt.mode = ST_RUN;
          s_nxt.out_en = 1'b1;
        end
      end
      ST_RUN:
      begin
        if (!want_on)
        begin
          s_nxt.mode = ST_OFF;
          s_nxt.out_en = 1'b0;
        end
        else if (ov_fault)
        begin
          s_nxt.alert = 1'b1;
          if (s_r.ovact.act == ACT_HICCUP)
          begin
            s_nxt.out_en = 1'b0;
            s_nxt.wait_cnt = 32'h0;
            if (exhausted)
              s_nxt.mode = ST_LATCH;
            else
            begin
              s_nxt.mode = ST_WAIT;
              if (s_r.ovact.retry != RETRY_FOREVER)
                s_nxt.tries = s_r.tries + 7'h01;
            end
          end
          else if (s_r.ovact.act == ACT_LATCH)
          begin
            s_nxt.out_en = 1'b0;
            s_nxt.mode = ST_LATCH;
          end
        end
      end
      ST_WAIT:
      begin
        s_nxt.wait_cnt = s_r.wait_cnt + 32'h1;
        if (!want_on)
          s_nxt.mode = ST_OFF;
        else if (wait_done)
        begin
          s_nxt.mode = ST_RUN;
          s_nxt.out_en = 1'b1;
        end
      end
      ST_LATCH:
      begin
        s_nxt.out_en = 1'b0;
        if (re_en)
          s_nxt.mode = ST_OFF;
      end
    endcase
  end

  // State register
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      s_r <= RST_STATE;
    else
      s_r <= s_nxt;
  end

  // Outputs straight from state
  assign rsp_out = s_r.rsp;
  assign duty_cmd_out = s_r.duty_cmd;
  assign freq_out = s_r.freq;
  assign power_en_out = s_r.out_en;
  assign power_good_out = s_r.vin_ok;
  assign stagger_cfg_out = s_r.stag;
  assign sync_pin_out = s_r.sync_o;
  assign sync_pin_oe_out = s_r.sync_oe;
  assign sync_rx_out = s_r.sync_rx;
  assign alert_line_n_out = ~s_r.alert;
  assign alert_line_oe_out = s_r.alert;

  // Checks
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!arst_n_in);

  duty_clamp_a: assert property (
    (fx[3] > fx[4]) |=> (duty_cmd_out == $past(s_r.duty)))
    else $error("duty not clamped to ceiling");

  freq_lock_a: assert property (
    (cmd_in.valid && cmd_in.write && cmd_in.code == CMD_FREQ && power_en_out)
    |=> (rsp_out.refused && $stable(freq_out)))
    else $error("frequency changed while output on");

  pgood_on_a: assert property (
    (!power_good_out && fx[0] >= fx[1] && !(fx[0] <= fx[2])) |=> power_good_out)
    else $error("power good not raised at turn-on");

  pgood_off_a: assert property (
    (power_good_out && fx[0] <= fx[2]) |=> (!power_good_out ##1 !power_en_out))
    else $error("power good or output kept after turn-off");

  stag_fields_a: assert property (
    (cmd_in.valid && cmd_in.write && cmd_ok && cmd_in.code == CMD_STAG)
    |=> (stagger_cfg_out.grp == $past(cmd_in.wdata[11:8]) &&
         stagger_cfg_out.cnt == $past(cmd_in.wdata[7:4]) &&
         stagger_cfg_out.pos == $past(cmd_in.wdata[3:0])))
    else $error("stagger fields misplaced");

  sync_role_a: assert property (
    (sync_rx_out || sync_pin_out) |-> (sync_pin_oe_out == sync_pin_out &&
                                       ($past(stagger_cfg_out.pos) == 4'h0) == sync_pin_out))
    else $error("sync role does not follow position");

  alert_hold_a: assert property (
    (s_r.mode == ST_RUN && want_on && ov_fault) |=> (!alert_line_n_out && alert_line_oe_out)
    ##1 (alert_line_oe_out || $past(re_en)))
    else $error("alert not pulled and held");

  ov_init_a: assert property (
    (!init_done_in && !alert_line_oe_out) |=> !alert_line_oe_out)
    else $error("over-voltage seen before init");

  hiccup_off_a: assert property (
    (s_r.mode == ST_RUN && want_on && ov_fault && s_r.ovact.act == ACT_HICCUP)
    |=> (!power_en_out && (s_r.mode == ST_WAIT || s_r.mode == ST_LATCH)))
    else $error("hiccup did not shut output");

  latch_hold_a: assert property (
    (s_r.mode == ST_LATCH && !re_en) |=> (s_r.mode == ST_LATCH && !power_en_out))
    else $error("latched output came back");

  retry_limit_a: assert property (
    (s_r.mode == ST_RUN && want_on && ov_fault && s_r.ovact.act == ACT_HICCUP && exhausted)
    |=> s_r.mode == ST_LATCH)
    else $error("retries not bounded");

  hiccup_wait_a: assert property (
    (s_r.mode == ST_WAIT && want_on && !wait_done) |=> !power_en_out)
    else $error("restart before hiccup delay");

  readback_a: assert property (
    (cmd_in.valid && cmd_in.write && cmd_ok && cmd_in.code == CMD_DUTY)
    ##1 (cmd_in.valid && !cmd_in.write && cmd_in.word && cmd_in.code == CMD_DUTY)
    |=> (rsp_out.rdata == $past(cmd_in.wdata, 2)))
    else $error("read does not return last value");

  latch_seen_c: cover property (s_r.mode == ST_RUN ##1 s_r.mode == ST_LATCH);
  hiccup_seen_c: cover property (s_r.mode == ST_WAIT ##1 s_r.mode == ST_RUN);
  pgood_seen_c: cover property ($rose(power_good_out));
  sync_seen_c: cover property (sync_rx_out);

endmodule

// *** core/cpc_lin11_fix.sv ***
// Linear11 to signed fixed point converter, one comparison operand
`timescale 1ns/1ps
module cpc_lin11_fix
  import cpc_pkg::*;
#(
  parameter int unsigned FRAC = L11_FRAC
)
(
  // Encoded value
  input  wire logic [15:0]        code_in,
  // Fixed point value, FRAC fraction bits
  output logic signed [47:0]      fix_out
);

  logic [5:0] shift;

  // Exponent is signed five bits; FRAC of 16 keeps the shift non-negative
  assign shift = {code_in[15], code_in[15:11]} + 6'(FRAC);

  // Sign-extended mantissa moved by the biased exponent
  assign fix_out = $signed({{37{code_in[10]}}, code_in[10:0]}) <<< shift[4:0];

endmodule

// *** core/cpc_pkg.sv ***
// Package: constants and types of the converter configuration and protection bank
// Summary of operation
// - Hold 16-bit linear11 duty ceiling; clamp power stage duty to it.
// - Hold 16-bit linear11 switching frequency; refuse writes while output enabled.
// - Input at or above turn-on threshold starts operation and raises power good.
// - Input at or below turn-off threshold stops operation and drops power good.
// - Stagger bits 11:8 hold the group identifier, 0 to 15.
// - Stagger bits 7:4 hold the member count of the group, 0 to 15.
// - Stagger bits 3:0 hold this unit's position, 0 to 15.
// - Position zero drives sync pulses; other positions receive them.
// - Output above ulinear16 limit pulls alert low, holds it, takes configured action.
// - Over-voltage is evaluated only after initialisation completes.
// - Action 01 shuts output down, then retries per retry field bits 5:3.
// - Action 11 latches output off until pin, command, off/on or input cycle.
// - Retry codes give 1 to 64 attempts; 111 retries forever; exhausted shuts off.
// - Bits 2:0 set hiccup off time, two to the code times 100 ms.
package cpc_pkg;

  // Command codes
  localparam logic [7:0] CMD_DUTY  = 8'h32;
  localparam logic [7:0] CMD_FREQ  = 8'h33;
  localparam logic [7:0] CMD_VON   = 8'h35;
  localparam logic [7:0] CMD_VOFF  = 8'h36;
  localparam logic [7:0] CMD_STAG  = 8'h37;
  localparam logic [7:0] CMD_OVLIM = 8'h40;
  localparam logic [7:0] CMD_OVACT = 8'h41;

  // Protection action codes
  localparam logic [1:0] ACT_HICCUP    = 2'h1;
  localparam logic [1:0] ACT_LATCH     = 2'h3;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  // Timing
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned HICCUP_UNIT_MS  = 100;
  localparam int unsigned HICCUP_UNIT_CYC = HICCUP_UNIT_MS * (CLK_HZ / 1000);
  localparam int unsigned SYNC_DEPTH      = 3;
  localparam int unsigned L11_FRAC        = 16;

  typedef enum logic [1:0] {
    ST_OFF   = 2'h0,
    ST_RUN   = 2'h1,
    ST_WAIT  = 2'h3,
    ST_LATCH = 2'h2
  } cpc_mode_t;

  typedef struct packed {
    logic [3:0] rsv;
    logic [3:0] grp;
    logic [3:0] cnt;
    logic [3:0] pos;
  } cpc_stag_t;

  typedef struct packed {
    logic [1:0] act;
    logic [2:0] retry;
    logic [2:0] dly;
  } cpc_act_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        word;
    logic [7:0]  code;
    logic [15:0] wdata;
  } cpc_cmd_t;

  typedef struct packed {
    logic        valid;
    logic        refused;
    logic [15:0] rdata;
  } cpc_rsp_t;

  typedef struct packed {
    logic [15:0] duty;
    logic [15:0] freq;
    logic [15:0] von;
    logic [15:0] voff;
    cpc_stag_t   stag;
    logic [15:0] ovlim;
    cpc_act_t    ovact;
    logic [2:0]  ctrl_s;
    logic        ctrl_f;
    logic [2:0]  sync_s;
    logic        sync_f;
    logic        op_q;
    cpc_mode_t   mode;
    logic        vin_ok;
    logic [6:0]  tries;
    logic [31:0] wait_cnt;
    logic        alert;
    logic        out_en;
    logic [15:0] duty_cmd;
    logic        sync_o;
    logic        sync_oe;
    logic        sync_rx;
    cpc_rsp_t    rsp;
  } cpc_state_t;

  // Values after reset
  localparam logic [15:0] RST_DUTY  = 16'h0000;
  localparam logic [15:0] RST_FREQ  = 16'h0000;
  localparam logic [15:0] RST_VON   = 16'h0000;
  localparam logic [15:0] RST_VOFF  = 16'h0000;
  localparam cpc_stag_t   RST_STAG  = 16'h0000;
  localparam logic [15:0] RST_OVLIM = 16'hffff;
  localparam cpc_act_t    RST_OVACT = 8'hc0;
  localparam cpc_state_t  RST_STATE = '{duty: RST_DUTY, freq: RST_FREQ, von: RST_VON,
    voff: RST_VOFF, stag: RST_STAG, ovlim: RST_OVLIM, ovact: RST_OVACT, mode: ST_OFF,
    rsp: '0, default: '0};

endpackage

// *** verification/cpc_config_protect_tb.sv ***
// Self-checking bench of the configuration and protection bank
`timescale 1ns/1ps
module cpc_config_protect_tb;
  import cpc_pkg::*;

  typedef struct packed {
    logic        wr;
    logic        wd;
    logic [7:0]  code;
    logic [15:0] wdata;
    logic        refused;
    logic [15:0] rdata;
  } cpc_row_t;

  logic      ref_clk, arst_n, init_done, op_on, ctrl, pwm_start, sync_ext, sync_wire;
  logic      pen, pen_q, pg, sync_o, sync_oe, sync_rx, alert_n, alert_oe;
  logic [15:0] vin, vout, duty_req, duty_cmd, freq;
  cpc_cmd_t  cmd;
  cpc_rsp_t  rsp, r;
  cpc_stag_t stag;
  int        n_fail, total_checks, n_rise, n_rx, n_tx, n, base, tx0;
  cpc_row_t  rows [0:17];

  // Sync wire: the design drives it only while master
  assign sync_wire = sync_oe ? sync_o : sync_ext;

  cpc_host_model cpc_host_model_i (.ref_clk_in(ref_clk), .cmd_out(cmd), .rsp_in(rsp));

  cpc_config_protect #(.HICCUP_CYC(10)) cpc_config_protect_i (
    .ref_clk_in(ref_clk), .arst_n_in(arst_n), .cmd_in(cmd), .rsp_out(rsp),
    .vin_meas_in(vin), .vout_meas_in(vout), .init_done_in(init_done),
    .operation_on_in(op_on), .ctrl_pin_in(ctrl), .duty_req_in(duty_req),
    .pwm_cycle_start_in(pwm_start), .duty_cmd_out(duty_cmd), .freq_out(freq),
    .power_en_out(pen), .power_good_out(pg), .stagger_cfg_out(stag),
    .sync_pin_in(sync_wire), .sync_pin_out(sync_o), .sync_pin_oe_out(sync_oe),
    .sync_rx_out(sync_rx), .alert_line_n_out(alert_n), .alert_line_oe_out(alert_oe));

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Event counters sampled on the clock; this process alone drives them, cleared under reset
  always @(posedge ref_clk)
  begin
    if (!arst_n)
    begin
      pen_q     <= 1'b0;
      n_rise    <= 0;
      n_rx      <= 0;
      n_tx      <= 0;
      pwm_start <= 1'b0;
    end
    else
    begin
      pen_q     <= pen;
      n_rise    <= n_rise + int'(pen & ~pen_q);
      n_rx      <= n_rx + int'(sync_rx);
      n_tx      <= n_tx + int'(sync_o);
      pwm_start <= ~pwm_start;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    begin
      total_checks++;
      if (got !== exp)
      begin
        n_fail++;
        $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task automatic cyc(input int k);
    begin
      repeat (k) @(posedge ref_clk);
      #1;
    end
  endtask

  // Bounded wait for the output enable to reach a level; k counts edges
  task automatic wait_pen(input logic v, output int k);
    begin
      k = 0;
      while (pen !== v && k < 500)
      begin
        cyc(1);
        k++;
      end
    end
  endtask

  task automatic finish_test();
    begin
      if (n_fail == 0 && total_checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask

  // Watchdog, well beyond the expected run
  initial
  begin
    #400000;
    n_fail++;
    finish_test();
  end

  initial
  begin
    {n_fail, total_checks} = '0;
    {arst_n, init_done, op_on, ctrl, sync_ext} = '0;
    vin = 16'h0032;
    vout = 16'h0000;
    duty_req = 16'h0000;
    // Ordinary register traffic: reset values, write and read back, refusals
    rows = '{'{1'b0, 1'b1, 8'h32, 16'h0000, 1'b0, 16'h0000}, '{1'b0, 1'b1, 8'h40, 16'h0000, 1'b0, 16'hffff},
      '{1'b0, 1'b0, 8'h41, 16'h0000, 1'b0, 16'h00c0}, '{1'b1, 1'b1, 8'h32, 16'h0032, 1'b0, 16'h0000},
      '{1'b0, 1'b1, 8'h32, 16'h0000, 1'b0, 16'h0032}, '{1'b1, 1'b1, 8'h33, 16'h0640, 1'b0, 16'h0000},
      '{1'b0, 1'b1, 8'h33, 16'h0000, 1'b0, 16'h0640}, '{1'b1, 1'b1, 8'h37, 16'h0a53, 1'b0, 16'h0000},
      '{1'b0, 1'b1, 8'h37, 16'h0000, 1'b0, 16'h0a53}, '{1'b1, 1'b0, 8'h41, 16'h0049, 1'b0, 16'h0000},
      '{1'b0, 1'b0, 8'h41, 16'h0000, 1'b0, 16'h0049}, '{1'b1, 1'b0, 8'h32, 16'h0011, 1'b1, 16'h0000},
      '{1'b0, 1'b1, 8'h41, 16'h0000, 1'b1, 16'h0000}, '{1'b0, 1'b1, 8'h99, 16'h0000, 1'b1, 16'h0000},
      '{1'b1, 1'b1, 8'h40, 16'h1000, 1'b0, 16'h0000}, '{1'b0, 1'b1, 8'h40, 16'h0000, 1'b0, 16'h1000},
      '{1'b1, 1'b1, 8'h35, 16'h0030, 1'b0, 16'h0000}, '{1'b1, 1'b1, 8'h36, 16'h0028, 1'b0, 16'h0000}};
    cyc(4);
    arst_n <= 1'b1;
    cyc(2);
    chk(16'({alert_n, alert_oe, pen, pg}), 16'h0009);
    foreach (rows[i])
    begin
      cpc_host_model_i.xfer(rows[i].wr, rows[i].wd, rows[i].code, rows[i].wdata, r);
      chk({r.valid, 14'h0, r.refused}, {1'b1, 14'h0, rows[i].refused});
      chk(r.rdata, rows[i].rdata);
    end
    // Write then read in consecutive cycles, twice in a row
    cpc_host_model_i.wr_rd(8'h32, 16'h0021, r);
    chk(r.rdata, 16'h0021);
    cpc_host_model_i.wr_rd(8'h32, 16'h0032, r);
    chk(r.rdata, 16'h0032);
    chk(freq, 16'h0640);
    // Non-master position: receives pulses, drives nothing
    chk(stag, 16'h0a53);
    base = n_rx;
    @(posedge ref_clk);
    sync_ext <= 1'b1;
    cyc(5);
    sync_ext <= 1'b0;
    cyc(8);
    chk({sync_oe, 15'(n_rx - base)}, 16'h0001);
    // Position zero: drives the pin, reports no received pulse
    cpc_host_model_i.xfer(1'b1, 1'b1, 8'h37, 16'h0a50, r);
    base = n_rx;
    tx0 = n_tx;
    cyc(40);
    chk({sync_oe, 15'(n_rx - base)}, 16'h8000);
    // Enable the output and clamp duty
    @(posedge ref_clk);
    ctrl <= 1'b1;
    op_on <= 1'b1;
    duty_req <= 16'h0064;
    cyc(8);
    chk(16'({pen, pg}), 16'h0003);
    chk(duty_cmd, 16'h0032);
    duty_req <= 16'h0010;
    cyc(3);
    chk(duty_cmd, 16'h0010);
    chk(16'(n_tx > tx0), 16'h0001);
    cpc_host_model_i.xfer(1'b1, 1'b1, 8'h33, 16'h0320, r);
    chk({r.refused, 15'h0}, 16'h8000);
    chk(freq, 16'h0640);
    // Over-voltage ignored before initialisation completes
    @(posedge ref_clk);
    vout <= 16'h2000;
    cyc(10);
    chk(16'({pen, alert_oe}), 16'h0002);
    base = n_rise;
    init_done <= 1'b1;
    wait_pen(1'b0, n);
    chk(16'({alert_n, alert_oe}), 16'h0001);
    wait_pen(1'b1, n);
    chk(16'(n), 16'h0014);
    cyc(150);
    chk(16'(n_rise - base), 16'h0002);
    chk(16'({pen, alert_n}), 16'h0000);
    // Clear the latch by an operation enable edge
    vout <= 16'h0800;
    op_on <= 1'b0;
    cyc(3);
    op_on <= 1'b1;
    cyc(10);
    chk(16'({pen, alert_n}), 16'h0003);
    // Latched action: stays off until the control pin cycles
    cpc_host_model_i.xfer(1'b1, 1'b0, 8'h41, 16'h00c0, r);
    base = n_rise;
    @(posedge ref_clk);
    vout <= 16'h2000;
    cyc(80);
    chk({pen, alert_oe, 14'(n_rise - base)}, 16'h4000);
    vout <= 16'h0800;
    ctrl <= 1'b0;
    cyc(6);
    ctrl <= 1'b1;
    cyc(10);
    chk(16'({pen, alert_n}), 16'h0003);
    // Input falls to the turn-off threshold, then recovers
    vin <= 16'h0028;
    cyc(4);
    chk(16'({pen, pg}), 16'h0000);
    vin <= 16'h0032;
    cyc(8);
    chk(16'({pen, pg}), 16'h0003);
    // Reset in mid-run: outputs and settings go back to their reset values
    @(posedge ref_clk);
    arst_n <= 1'b0;
    cyc(2);
    chk(16'({alert_n, alert_oe, pen, sync_oe}), 16'h0008);
    chk(stag, 16'h0000);
    chk(freq, 16'h0000);
    arst_n <= 1'b1;
    cyc(2);
    cpc_host_model_i.xfer(1'b0, 1'b1, 8'h40, 16'h0000, r);
    chk(r.rdata, 16'hffff);
    chk(16'(sync_oe), 16'h0001);
    finish_test();
  end
endmodule

// *** verification/cpc_host_model.sv ***
// Host-side model that issues command port transfers
`timescale 1ns/1ps
module cpc_host_model
  import cpc_pkg::*;
(
  // Clock
  input  wire logic     ref_clk_in,
  // Command port
  output cpc_cmd_t      cmd_out,
  input  wire cpc_rsp_t rsp_in
);
  initial cmd_out = '0;

  // One request cycle, answer taken one edge later; word or byte as the command asks
  // Idle lines show inverted data so a stale value is never mistaken for a live one
  task automatic xfer(input logic wr, input logic wd, input logic [7:0] code,
                      input logic [15:0] wdata, output cpc_rsp_t rsp);
    begin
      @(posedge ref_clk_in);
      cmd_out <= '{valid: 1'b1, write: wr, word: wd, code: code, wdata: wdata};
      @(posedge ref_clk_in);
      cmd_out <= '{valid: 1'b0, write: ~wr, word: ~wd, code: ~code, wdata: ~wdata};
      #1;
      rsp = rsp_in;
    end
  endtask

  // Word write and read of one code in back-to-back cycles; answer of the read is returned
  task automatic wr_rd(input logic [7:0] code, input logic [15:0] wdata, output cpc_rsp_t rsp);
    begin
      @(posedge ref_clk_in);
      cmd_out <= '{valid: 1'b1, write: 1'b1, word: 1'b1, code: code, wdata: wdata};
      @(posedge ref_clk_in);
      cmd_out <= '{valid: 1'b1, write: 1'b0, word: 1'b1, code: code, wdata: 16'h0000};
      @(posedge ref_clk_in);
      cmd_out <= '{valid: 1'b0, write: 1'b1, word: 1'b0, code: ~code, wdata: ~wdata};
      #1;
      rsp = rsp_in;
    end
  endtask
endmodule
